/* design/stp_pkg.sv */
// Purpose: Shared constants and carrier types for the single-pulse/capture timer
// Assumes: 10-bit counter, AXI4-Lite register access with 32-bit data
// Notes: Register offsets are byte addresses
package stp_pkg;
   localparam int CNT_W = 10;
   localparam logic [9:0] CNT_MAX = 10'h3FF;
   // Register byte offsets
   localparam logic [7:0] OFS_CTRL0 = 8'h00;
   localparam logic [7:0] OFS_CTRL1 = 8'h04;
   localparam logic [7:0] OFS_COUNT = 8'h08;
   localparam logic [7:0] OFS_CMPA = 8'h0C;
   localparam logic [7:0] OFS_CMPP = 8'h10;
   localparam logic [7:0] OFS_STAT = 8'h14;
   // Control0 field positions
   localparam int CTRL0_RUN = 0;
   localparam int CTRL0_PAUSE = 1;
   localparam int CTRL0_CLK_LO = 4;
   // Control1 field positions
   localparam int CTRL1_CCLR = 0;
   localparam int CTRL1_DPX = 1;
   localparam int CTRL1_POL = 2;
   localparam int CTRL1_OC = 3;
   localparam int CTRL1_PF_LO = 4;
   localparam int CTRL1_MS_LO = 6;
   // Status field positions
   localparam int STAT_AF = 0;
   localparam int STAT_PF = 1;
   // Mode-select encodings
   localparam logic [1:0] MODE_CMP = 2'h0;
   localparam logic [1:0] MODE_CAP = 2'h1;
   localparam logic [1:0] MODE_PWM = 2'h2;
   localparam logic [1:0] MODE_TMR = 2'h3;
   // Pin-function encodings
   localparam logic [1:0] PF_INACT = 2'h0;
   localparam logic [1:0] PF_ACT = 2'h1;
   localparam logic [1:0] PF_PWM = 2'h2;
   localparam logic [1:0] PF_SINGLE = 2'h3;
   // Timer clock selections
   localparam logic [2:0] CKS_DIV4 = 3'h0;
   localparam logic [2:0] CKS_SYS = 3'h1;
   localparam logic [2:0] CKS_DIV16 = 3'h2;
   localparam logic [2:0] CKS_DIV64 = 3'h3;
   localparam logic [2:0] CKS_PIN_R = 3'h6;
   localparam logic [2:0] CKS_PIN_F = 3'h7;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   typedef struct packed {
      logic [1:0] mode_select_field;
      logic [1:0] pin_function_field;
      logic output_initial_level;
      logic output_polarity_invert;
      logic duty_period_swap;
      logic clear_source_select;
   } stp_ctrl1_t;
endpackage // stp_pkg

/* design/stp_timer.sv */
// Purpose: Standard timer core: single-pulse, capture and PWM modes
// Assumes: Pins synchronous to CLK; AXI4-Lite slave for the registers
// Notes: Compare-match mode counts as timer mode here but drives the output enable; output in that mode holds
// Function
// - PWM waveform runs even when output forced
// - Counter clear ends and starts a PWM period
// - Clear-source bit ignored in PWM mode
// - Single pulse when mode 10 and pins 11
// - Trigger pin edge sets run bit
// - Run rising edge starts count and pulse
// - Compare-A or software clear ends pulse
// - Compare-A match in single pulse raises interrupt
// - Single pulse counter zeroes only on run rise
// - Single pulse ignores compare-P, clear-source, swap
// - Capture mode when mode field is 01
// - Capture counter starts from zero on run rise
// - Capture edge copies count into compare-A, interrupt
// - Capture counter free runs until run falls
// - Compare-P match clears counter, raises interrupt
// - Compare-P zero lets counter reach maximum
// - Edges rising, falling, both; 11 disables capture
// - Capture mode drives no output
// - Ten-bit counter wraps after 3FF
// - Run rising edge restores output initial level outside single pulse
//
// The placing of the registers and the AXI4-Lite slave port were left to the implementer.
module stp_timer
(
   // Clock and reset
   input wire logic CLK,
   input wire logic RST_N,
   // AXI4-Lite write address and data
   input wire logic [7:0] AWADDR,
   input wire logic AWVALID,
   output logic AWREADY,
   input wire logic [31:0] WDATA,
   input wire logic [3:0] WSTRB,
   input wire logic WVALID,
   output logic WREADY,
   // AXI4-Lite write response
   output logic [1:0] BRESP,
   output logic BVALID,
   input wire logic BREADY,
   // AXI4-Lite read
   input wire logic [7:0] ARADDR,
   input wire logic ARVALID,
   output logic ARREADY,
   output logic [31:0] RDATA,
   output logic [1:0] RRESP,
   output logic RVALID,
   input wire logic RREADY,
   // Timer pins
   input wire logic TRIG_CLK_PIN,
   input wire logic CAPTURE_PIN,
   output logic TIMER_OUT,
   output logic TIMER_OUT_EN,
   output logic TIMER_IRQ
);
   ////////////////////////////////////////////////////////////////////////////
   // Register state
   logic counter_run_bit;
   logic pause;
   logic [2:0] clk_sel;
   stp_pkg::stp_ctrl1_t ctrl1;
   logic [9:0] count;
   logic [9:0] compare_a_value;
   logic [9:0] compare_p_value;
   logic flag_a;
   logic flag_p;
   logic run_q;
   logic out_lvl;
   logic trig_q;
   logic cap_q;
   logic [5:0] prescale;
   logic have_aw;
   logic have_w;
   logic [7:0] aw_addr;
   logic [31:0] w_data;
   logic [3:0] w_strb;

   ////////////////////////////////////////////////////////////////////////////
   // Mode decode
   wire mode_cap = ctrl1.mode_select_field == stp_pkg::MODE_CAP;
   wire mode_pwm_grp = ctrl1.mode_select_field == stp_pkg::MODE_PWM;
   wire mode_single = mode_pwm_grp && ctrl1.pin_function_field == stp_pkg::PF_SINGLE;
   wire mode_pwm = mode_pwm_grp && !mode_single;
   wire run_rise = counter_run_bit && !run_q;
   wire trig_rise = TRIG_CLK_PIN && !trig_q;
   wire trig_fall = !TRIG_CLK_PIN && trig_q;
   wire cap_rise = CAPTURE_PIN && !cap_q;
   wire cap_fall = !CAPTURE_PIN && cap_q;

   // Timer clock tick: prescaled system clock or trigger pin edges
   wire tick_sel =
      (clk_sel == stp_pkg::CKS_SYS) ? 1'b1 :
      (clk_sel == stp_pkg::CKS_DIV4) ? (prescale[1:0] == 2'h3) :
      (clk_sel == stp_pkg::CKS_DIV16) ? (prescale[3:0] == 4'hF) :
      (clk_sel == stp_pkg::CKS_DIV64) ? (prescale == 6'h3F) :
      (clk_sel == stp_pkg::CKS_PIN_R) ? trig_rise :
      (clk_sel == stp_pkg::CKS_PIN_F) ? trig_fall : 1'b1;
   wire tick = counter_run_bit && !run_rise && !pause && tick_sel;

   // Comparators evaluated on the counter value reached on a tick
   wire [9:0] count_inc = count + 10'h001;
   wire p_full = compare_p_value == 10'h000;
   wire match_p = tick && (p_full ? (count == stp_pkg::CNT_MAX)
                                  : (count_inc == compare_p_value));
   wire match_a = tick && (count_inc == compare_a_value);

   // PWM period/duty selection; clear-source bit never consulted here
   wire [9:0] pwm_period = ctrl1.duty_period_swap ? compare_a_value : compare_p_value;
   wire [9:0] pwm_duty = ctrl1.duty_period_swap ? compare_p_value : compare_a_value;
   wire pwm_full = (pwm_period == 10'h000) ? (count == stp_pkg::CNT_MAX)
                                           : (count_inc == pwm_period);
   wire pwm_end = tick && pwm_full;
   wire pwm_active = count < pwm_duty;

   // Generic clear for compare/timer modes
   wire gen_clr = ctrl1.clear_source_select ? match_a : match_p;

   // Capture edge selection
   wire cap_edge =
      (ctrl1.pin_function_field == 2'h0) ? cap_rise :
      (ctrl1.pin_function_field == 2'h1) ? cap_fall :
      (ctrl1.pin_function_field == 2'h2) ? (cap_rise || cap_fall) : 1'b0;
   wire do_capture = mode_cap && counter_run_bit && cap_edge;

   // Next counter value
   wire [9:0] next_count =
      run_rise ? 10'h000 :
      !tick ? count :
      mode_single ? count_inc :
      mode_cap ? (match_p ? 10'h000 : count_inc) :
      mode_pwm ? (pwm_end ? 10'h000 : count_inc) :
      (gen_clr ? 10'h000 : count_inc);

   // Interrupt sources per mode
   wire set_a = mode_single ? match_a :
                mode_cap ? do_capture :
                match_a;
   wire set_p = mode_single ? 1'b0 :
                mode_cap ? match_p :
                !(ctrl1.clear_source_select && !mode_pwm) && match_p;

   // Output level before polarity
   wire pwm_lvl =
      (ctrl1.pin_function_field == stp_pkg::PF_INACT) ? !ctrl1.output_initial_level :
      (ctrl1.pin_function_field == stp_pkg::PF_ACT) ? ctrl1.output_initial_level :
      (pwm_active ? ctrl1.output_initial_level : !ctrl1.output_initial_level);
   wire single_lvl = counter_run_bit ? !ctrl1.output_initial_level
                                     : ctrl1.output_initial_level;
   wire next_out_lvl =
      run_rise && !mode_single ? ctrl1.output_initial_level :
      mode_single ? single_lvl :
      mode_pwm ? pwm_lvl :
      out_lvl;

   ////////////////////////////////////////////////////////////////////////////
   // AXI4-Lite decode
   wire aw_take = AWVALID && AWREADY;
   wire w_take = WVALID && WREADY;
   wire wr_go = have_aw && have_w && !BVALID;
   wire wr_ok = aw_addr == stp_pkg::OFS_CTRL0 || aw_addr == stp_pkg::OFS_CTRL1 ||
                aw_addr == stp_pkg::OFS_CMPA || aw_addr == stp_pkg::OFS_CMPP ||
                aw_addr == stp_pkg::OFS_STAT;
   wire wr_ctrl0 = wr_go && aw_addr == stp_pkg::OFS_CTRL0 && w_strb[0];
   wire wr_ctrl1 = wr_go && aw_addr == stp_pkg::OFS_CTRL1 && w_strb[0];
   wire wr_cmpa = wr_go && aw_addr == stp_pkg::OFS_CMPA;
   wire wr_cmpp = wr_go && aw_addr == stp_pkg::OFS_CMPP;
   wire wr_stat = wr_go && aw_addr == stp_pkg::OFS_STAT && w_strb[0];
   wire [9:0] wa_merge = {w_strb[1] ? w_data[9:8] : compare_a_value[9:8],
                          w_strb[0] ? w_data[7:0] : compare_a_value[7:0]};
   wire [9:0] wp_merge = {w_strb[1] ? w_data[9:8] : compare_p_value[9:8],
                          w_strb[0] ? w_data[7:0] : compare_p_value[7:0]};
   wire rd_take = ARVALID && ARREADY;
   wire [31:0] rd_word =
      (ARADDR == stp_pkg::OFS_CTRL0) ? {25'h0, clk_sel, 2'h0, pause, counter_run_bit} :
      (ARADDR == stp_pkg::OFS_CTRL1) ? {24'h0, ctrl1} :
      (ARADDR == stp_pkg::OFS_COUNT) ? {22'h0, count} :
      (ARADDR == stp_pkg::OFS_CMPA) ? {22'h0, compare_a_value} :
      (ARADDR == stp_pkg::OFS_CMPP) ? {22'h0, compare_p_value} :
      (ARADDR == stp_pkg::OFS_STAT) ? {30'h0, flag_p, flag_a} : 32'h0;
   wire rd_ok = ARADDR == stp_pkg::OFS_CTRL0 || ARADDR == stp_pkg::OFS_CTRL1 ||
                ARADDR == stp_pkg::OFS_COUNT || ARADDR == stp_pkg::OFS_CMPA ||
                ARADDR == stp_pkg::OFS_CMPP || ARADDR == stp_pkg::OFS_STAT;

   // One write held at a time; read accepted when no answer is pending
   assign AWREADY = !have_aw;
   assign WREADY = !have_w;
   assign ARREADY = !RVALID;
   assign TIMER_IRQ = flag_a || flag_p;
   assign TIMER_OUT = out_lvl ^ ctrl1.output_polarity_invert;
   assign TIMER_OUT_EN = (mode_single || mode_pwm || ctrl1.mode_select_field ==
                          stp_pkg::MODE_CMP) && !mode_cap;

   // Run bit: software, trigger pin, compare-A end of pulse
   wire sw_run = wr_ctrl0 ? w_data[stp_pkg::CTRL0_RUN] : counter_run_bit;
   wire next_run =
      (mode_single && counter_run_bit && match_a) ? 1'b0 :
      (mode_single && !counter_run_bit && trig_rise) ? 1'b1 :
      sw_run;

   ////////////////////////////////////////////////////////////////////////////
   // Bus channel state
   always_ff @(posedge CLK or negedge RST_N)
   begin
      if (!RST_N)
      begin
         have_aw <= 1'b0;
         have_w <= 1'b0;
         aw_addr <= 8'h00;
         w_data <= 32'h0;
         w_strb <= 4'h0;
         BVALID <= 1'b0;
         BRESP <= stp_pkg::RESP_OKAY;
      end
      else
      begin
         if (aw_take)
         begin
            have_aw <= 1'b1;
            aw_addr <= AWADDR;
         end
         if (w_take)
         begin
            have_w <= 1'b1;
            w_data <= WDATA;
            w_strb <= WSTRB;
         end
         if (wr_go)
         begin
            have_aw <= 1'b0;
            have_w <= 1'b0;
            BVALID <= 1'b1;
            BRESP <= wr_ok ? stp_pkg::RESP_OKAY : stp_pkg::RESP_SLVERR;
         end
         else if (BVALID && BREADY)
            BVALID <= 1'b0;
      end
   end

   // Read answer registered
   always_ff @(posedge CLK or negedge RST_N)
   begin
      if (!RST_N)
      begin
         RVALID <= 1'b0;
         RDATA <= 32'h0;
         RRESP <= stp_pkg::RESP_OKAY;
      end
      else if (rd_take)
      begin
         RVALID <= 1'b1;
         RDATA <= rd_word;
         RRESP <= rd_ok ? stp_pkg::RESP_OKAY : stp_pkg::RESP_SLVERR;
      end
      else if (RREADY)
         RVALID <= 1'b0;
   end

   ////////////////////////////////////////////////////////////////////////////
   // Control registers
   always_ff @(posedge CLK or negedge RST_N)
   begin
      if (!RST_N)
      begin
         counter_run_bit <= 1'b0;
         pause <= 1'b0;
         clk_sel <= stp_pkg::CKS_DIV4;
         ctrl1 <= '0;
      end
      else
      begin
         counter_run_bit <= next_run;
         if (wr_ctrl0)
         begin
            pause <= w_data[stp_pkg::CTRL0_PAUSE];
            clk_sel <= w_data[stp_pkg::CTRL0_CLK_LO +: 3];
         end
         if (wr_ctrl1)
            ctrl1 <= w_data[7:0];
      end
   end

   // Compare values; a capture wins over a software write in the same cycle
   always_ff @(posedge CLK or negedge RST_N)
   begin
      if (!RST_N)
      begin
         compare_a_value <= 10'h000;
         compare_p_value <= 10'h000;
      end
      else
      begin
         if (do_capture)
            compare_a_value <= count;
         else if (wr_cmpa)
            compare_a_value <= wa_merge;
         if (wr_cmpp)
            compare_p_value <= wp_merge;
      end
   end

   // Sticky flags: hardware set wins over write-one-to-clear
   always_ff @(posedge CLK or negedge RST_N)
   begin
      if (!RST_N)
      begin
         flag_a <= 1'b0;
         flag_p <= 1'b0;
      end
      else
      begin
         flag_a <= set_a || (flag_a && !(wr_stat && w_data[stp_pkg::STAT_AF]));
         flag_p <= set_p || (flag_p && !(wr_stat && w_data[stp_pkg::STAT_PF]));
      end
   end

   // Counter, edge history, prescaler, output
   always_ff @(posedge CLK or negedge RST_N)
   begin
      if (!RST_N)
      begin
         count <= 10'h000;
         run_q <= 1'b0;
         trig_q <= 1'b0;
         cap_q <= 1'b0;
         prescale <= 6'h00;
         out_lvl <= 1'b0;
      end
      else
      begin
         count <= next_count;
         run_q <= counter_run_bit;
         trig_q <= TRIG_CLK_PIN;
         cap_q <= CAPTURE_PIN;
         prescale <= prescale + 6'h01;
         out_lvl <= next_out_lvl;
      end
   end
endmodule // stp_timer

/* test/stp_pin_src.sv */
// Purpose: Outside sources for the trigger and capture pins
// Assumes: Bench trigger commands arrive as one-cycle pulses; the capture command is a held level
// Notes: A long delay stands for a slow source
module stp_pin_src
(
   // Clock and commands
   input wire logic CLK,
   input wire logic trig_go,
   input wire logic [3:0] dly,
   input wire logic cap_lvl,
   // Pins toward the timer
   output logic TRIG_CLK_PIN,
   output logic CAPTURE_PIN = 1'b0
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [4:0] tcnt = 5'h00;
   // Two-cycle trigger pulse after the delay
   always @(posedge CLK)
   begin
      if (trig_go)
         tcnt <= 5'(dly) + 5'h03;
      else if (tcnt != 5'h00)
         tcnt <= tcnt - 5'h01;
   end
   assign TRIG_CLK_PIN = (tcnt == 5'h01) || (tcnt == 5'h02);
   // Capture level lags the command by a cycle
   always @(posedge CLK)
      CAPTURE_PIN <= cap_lvl;
endmodule // stp_pin_src

/* test/stp_timer_monitor.sv */
// Purpose: Port-level checker for the pulse and capture timer
// Assumes: Bench offers write address and data together
// Notes: Mode, levels and run are shadowed from seen writes
module stp_timer_monitor
(
   // Clock and reset
   input wire logic CLK,
   input wire logic RST_N,
   // Bus
   input wire logic [7:0] AWADDR,
   input wire logic AWVALID,
   input wire logic AWREADY,
   input wire logic [31:0] WDATA,
   input wire logic WVALID,
   input wire logic WREADY,
   input wire logic [1:0] BRESP,
   input wire logic BVALID,
   input wire logic BREADY,
   input wire logic ARVALID,
   input wire logic ARREADY,
   input wire logic [31:0] RDATA,
   input wire logic RVALID,
   input wire logic RREADY,
   // Pins
   input wire logic TRIG_CLK_PIN,
   input wire logic CAPTURE_PIN,
   input wire logic TIMER_OUT,
   input wire logic TIMER_OUT_EN,
   input wire logic TIMER_IRQ
);
   default clocking cb @(posedge CLK);
   endclocking
   default disable iff (!RST_N);
   logic [3:0] mode_pf;
   logic idle;
   logic run_sh;
   logic cap_q;
   logic [2:0] c0_hist;
   // Write decode; a software control write excuses an output edge for three cycles,
   // since the register lands one cycle after the take and the output a cycle later
   wire wr_go = AWVALID && AWREADY && WVALID && WREADY;
   wire c0_wr = wr_go && (AWADDR == stp_pkg::OFS_CTRL0);
   wire c1_wr = wr_go && (AWADDR == stp_pkg::OFS_CTRL1);
   wire st_wr = wr_go && (AWADDR == stp_pkg::OFS_STAT);
   wire sp = mode_pf == {stp_pkg::MODE_PWM, stp_pkg::PF_SINGLE};
   wire capm = mode_pf[3:2] == stp_pkg::MODE_CAP;
   wire pin_chg = CAPTURE_PIN != cap_q;
   wire pf_hit = (mode_pf[1:0] == 2'h2) || (mode_pf[1:0] == {1'b0, ~CAPTURE_PIN});
   wire edge_hit = capm && run_sh && pin_chg && pf_hit;
   wire sw_run = c0_wr || c1_wr || (|c0_hist);
   // Shadows of the control fields
   always_ff @(posedge CLK or negedge RST_N)
   begin
      if (!RST_N)
      begin
         mode_pf <= 4'h0;
         idle <= 1'b0;
      end
      else if (wr_go && (AWADDR == stp_pkg::OFS_CTRL1))
      begin
         mode_pf <= WDATA[7:4];
         idle <= WDATA[3] ^ WDATA[2];
      end
   end
   // Run shadow and pin history
   always_ff @(posedge CLK or negedge RST_N)
   begin
      if (!RST_N)
      begin
         run_sh <= 1'b0;
         cap_q <= 1'b0;
         c0_hist <= 3'h0;
      end
      else
      begin
         run_sh <= c0_wr ? WDATA[0] : run_sh;
         cap_q <= CAPTURE_PIN;
         c0_hist <= {c0_hist[1:0], c0_wr || c1_wr};
      end
   end
   // Both halves are held one cycle before the answer is raised
   a_write_answer: assert property (wr_go |-> ##2 BVALID)
      else $error("write not answered");
   a_bvalid_stand: assert property (BVALID && !BREADY |=> BVALID && $stable(BRESP))
      else $error("write response dropped");
   a_read_answer: assert property (ARVALID && ARREADY |=> RVALID)
      else $error("read not answered");
   a_rdata_stand: assert property (RVALID && !RREADY |=> RVALID && $stable(RDATA))
      else $error("read data dropped");
   a_sp_drives: assert property (sp && $past(sp) |-> TIMER_OUT_EN)
      else $error("single pulse output not driven");
   a_cap_quiet: assert property (capm && $past(capm) |-> !TIMER_OUT_EN)
      else $error("capture mode drives output");
   a_trig_starts: assert property (sp && $past(sp) && $rose(TRIG_CLK_PIN) && TIMER_OUT == idle
      |-> ##[1:4] TIMER_OUT != idle)
      else $error("trigger gave no pulse");
   a_pulse_irq: assert property (sp && $past(sp) && !sw_run && $past(TIMER_OUT) != idle
      && TIMER_OUT == idle |-> ##[0:2] TIMER_IRQ)
      else $error("pulse end without interrupt");
   a_cap_flag: assert property (edge_hit |-> ##[1:4] TIMER_IRQ)
      else $error("capture edge without interrupt");
   a_irq_hold: assert property (TIMER_IRQ && !st_wr && !$past(st_wr) |=> TIMER_IRQ)
      else $error("interrupt dropped without clear");
endmodule // stp_timer_monitor

bind stp_timer stp_timer_monitor i_mon (.CLK, .RST_N, .AWADDR, .AWVALID, .AWREADY, .WDATA,
   .WVALID, .WREADY, .BRESP, .BVALID, .BREADY, .ARVALID, .ARREADY, .RDATA, .RVALID,
   .RREADY, .TRIG_CLK_PIN, .CAPTURE_PIN, .TIMER_OUT, .TIMER_OUT_EN, .TIMER_IRQ);

/* test/stp_timer_bench.sv */
// Purpose: Self-checking bench for the pulse and capture timer
// Assumes: Offsets and fields from the shared package
// Notes: Pulse width is checked in a window, the output lags run
module stp_timer_bench;
   timeunit 1ns;
   timeprecision 1ns;
   logic CLK, RST_N, AWVALID, WVALID, BREADY, ARVALID, RREADY, trig_go, cap_lvl;
   logic AWREADY, WREADY, BVALID, ARREADY, RVALID, TRIG_CLK_PIN, CAPTURE_PIN;
   logic TIMER_OUT, TIMER_OUT_EN, TIMER_IRQ;
   logic [7:0] AWADDR, ARADDR;
   logic [31:0] WDATA, RDATA, rv, rw;
   logic [3:0] WSTRB, dly;
   logic [1:0] BRESP, RRESP;
   int fail_count = 0;
   int check_count = 0;
   int cyc = 0;
   int w;
   stp_timer i_dut (.CLK, .RST_N, .AWADDR, .AWVALID, .AWREADY, .WDATA, .WSTRB, .WVALID,
      .WREADY, .BRESP, .BVALID, .BREADY, .ARADDR, .ARVALID, .ARREADY, .RDATA, .RRESP,
      .RVALID, .RREADY, .TRIG_CLK_PIN, .CAPTURE_PIN, .TIMER_OUT, .TIMER_OUT_EN, .TIMER_IRQ);
   stp_pin_src i_src (.CLK, .trig_go, .dly, .cap_lvl, .TRIG_CLK_PIN, .CAPTURE_PIN);
   ////////////////////////////////////////////////////////////////////////////////
   initial
   begin
      CLK = 1'b0;
      forever #5 CLK = ~CLK;
   end
   // Hang guard, well above the few thousand cycles needed
   always @(posedge CLK)
   begin
      cyc <= cyc + 1;
      if (cyc == 20000)
      begin
         fail_count++;
         report_and_stop();
      end
   end
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      check_count++;
      if (got !== exp)
      begin
         fail_count++;
         $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic report_and_stop();
      $display("Checks %0d mismatches %0d", check_count, fail_count);
      if (fail_count == 0 && check_count > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask
   // Write: both channels offered, each dropped once taken
   task automatic wr(input logic [7:0] a, input logic [31:0] d,
      input logic [1:0] er = stp_pkg::RESP_OKAY);
      logic da;
      logic dw;
      da = 1'b0;
      dw = 1'b0;
      @(posedge CLK);
      AWADDR <= a;
      WDATA <= d;
      AWVALID <= 1'b1;
      WVALID <= 1'b1;
      BREADY <= 1'b1;
      while (!(da && dw))
      begin
         @(negedge CLK);
         da = da || (AWVALID && AWREADY);
         dw = dw || (WVALID && WREADY);
         @(posedge CLK);
         if (da) AWVALID <= 1'b0;
         if (dw) WVALID <= 1'b0;
      end
      do @(negedge CLK); while (!BVALID);
      chk({30'h0, BRESP}, {30'h0, er});
      @(posedge CLK);
      BREADY <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, input logic [1:0] er = stp_pkg::RESP_OKAY);
      @(posedge CLK);
      ARADDR <= a;
      ARVALID <= 1'b1;
      RREADY <= 1'b1;
      do @(negedge CLK); while (!ARREADY);
      @(posedge CLK);
      ARVALID <= 1'b0;
      do @(negedge CLK); while (!RVALID);
      rv = RDATA;
      chk({30'h0, RRESP}, {30'h0, er});
      @(posedge CLK);
      RREADY <= 1'b0;
   endtask
   // One capture-pin edge, then the A flag against expectation
   task automatic edge_chk(input logic lvl, input logic ex);
      wr(stp_pkg::OFS_STAT, 32'h3);
      cap_lvl <= lvl;
      repeat (6) @(posedge CLK);
      rd(stp_pkg::OFS_STAT);
      chk({31'h0, rv[0]}, {31'h0, ex});
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   initial
   begin
      RST_N <= 1'b0;
      {AWVALID, WVALID, BREADY, ARVALID, RREADY, trig_go, cap_lvl} <= 7'h00;
      AWADDR <= 8'h00;
      ARADDR <= 8'h00;
      WDATA <= 32'h0;
      WSTRB <= 4'hF;
      dly <= 4'h1;
      repeat (10) @(posedge CLK);
      RST_N <= 1'b1;
      for (int a = 0; a < 24; a += 4)
      begin
         rd(8'(a));
         chk(rv, 32'h0);
      end
      rd(8'h18, stp_pkg::RESP_SLVERR);
      wr(stp_pkg::OFS_COUNT, 32'h5, stp_pkg::RESP_SLVERR);
      $display("Test reset and map done");
      // Pulse of width 20 with compare-P, clear and swap set
      wr(stp_pkg::OFS_CMPA, 32'h14);
      wr(stp_pkg::OFS_CMPP, 32'h5);
      wr(stp_pkg::OFS_CTRL0, 32'h10);
      wr(stp_pkg::OFS_CTRL1, 32'hBB);
      repeat (2) @(negedge CLK);
      chk({31'h0, TIMER_OUT}, 32'h1);
      w = 0;
      for (int i = 0; i < 120; i++)
      begin
         @(posedge CLK);
         trig_go <= (i == 0) || (i == 10);
         dly <= (i == 0) ? 4'h1 : 4'h5;
         @(negedge CLK);
         w += (TIMER_OUT === 1'b0);
      end
      chk({31'h0, w >= 20 && w <= 23}, 32'h1);
      rd(stp_pkg::OFS_COUNT);
      chk(rv, 32'h14);
      rd(stp_pkg::OFS_CTRL0);
      chk(rv, 32'h10);
      rd(stp_pkg::OFS_STAT);
      chk(rv, 32'h1);
      wr(stp_pkg::OFS_STAT, 32'h3);
      wr(stp_pkg::OFS_CTRL0, 32'h11);
      repeat (2) @(negedge CLK);
      chk({31'h0, TIMER_OUT}, 32'h0);
      rd(stp_pkg::OFS_COUNT);
      chk({31'h0, rv < 32'h14}, 32'h1);
      wr(stp_pkg::OFS_CTRL0, 32'h10);
      repeat (2) @(negedge CLK);
      chk({31'h0, TIMER_OUT}, 32'h1);
      rd(stp_pkg::OFS_STAT);
      chk(rv, 32'h0);
      $display("Test single pulse done");
      // Capture with output bits set, each edge selection
      wr(stp_pkg::OFS_CMPP, 32'h40);
      wr(stp_pkg::OFS_CMPA, 32'h3FF);
      wr(stp_pkg::OFS_CTRL1, 32'h4F);
      wr(stp_pkg::OFS_CTRL0, 32'h11);
      repeat (2) @(negedge CLK);
      chk({31'h0, TIMER_OUT_EN}, 32'h0);
      for (int pf = 0; pf < 4; pf++)
      begin
         wr(stp_pkg::OFS_CTRL1, 32'h4F | (32'(pf) << 4));
         edge_chk(1'b1, pf == 0 || pf == 2);
         edge_chk(1'b0, pf == 1 || pf == 2);
      end
      rd(stp_pkg::OFS_CMPA);
      chk({31'h0, rv <= 32'h40}, 32'h1);
      rd(stp_pkg::OFS_COUNT);
      rw = rv;
      rd(stp_pkg::OFS_COUNT);
      chk({31'h0, rv != rw}, 32'h1);
      wr(stp_pkg::OFS_STAT, 32'h3);
      repeat (70) @(posedge CLK);
      rd(stp_pkg::OFS_STAT);
      chk(rv & 32'h2, 32'h2);
      wr(stp_pkg::OFS_CMPP, 32'h0);
      wr(stp_pkg::OFS_STAT, 32'h3);
      repeat (300) @(posedge CLK);
      rd(stp_pkg::OFS_STAT);
      chk(rv & 32'h2, 32'h0);
      repeat (1024) @(posedge CLK);
      rd(stp_pkg::OFS_STAT);
      chk(rv & 32'h2, 32'h2);
      wr(stp_pkg::OFS_CTRL0, 32'h10);
      rd(stp_pkg::OFS_COUNT);
      rw = rv;
      repeat (10) @(posedge CLK);
      rd(stp_pkg::OFS_COUNT);
      chk(rv, rw);
      $display("Test capture done");
      // PWM, period 8 and duty 3; a live clear-source bit would shorten the period
      wr(stp_pkg::OFS_CMPA, 32'h3);
      wr(stp_pkg::OFS_CMPP, 32'h8);
      wr(stp_pkg::OFS_CTRL1, 32'hA9);
      wr(stp_pkg::OFS_CTRL0, 32'h11);
      repeat (2) @(negedge CLK);
      w = 0;
      repeat (64)
      begin
         @(negedge CLK);
         w += (TIMER_OUT === 1'b1);
      end
      chk(32'(w), 32'h18);
      // Forced inactive output, counter and comparators keep going
      wr(stp_pkg::OFS_CTRL1, 32'h89);
      wr(stp_pkg::OFS_STAT, 32'h3);
      repeat (20) @(negedge CLK);
      chk({31'h0, TIMER_OUT}, 32'h0);
      rd(stp_pkg::OFS_STAT);
      chk(rv, 32'h3);
      $display("Test pwm done");
      report_and_stop();
   end
endmodule // stp_timer_bench
